// *** core/rcr_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcr_config_regs
    import rcr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata,
    output logic [2:0] ramp_scale_d,
    output logic [4:0] ramp_scale_exp_d,
    output logic ramped_switch_enable_d,
    output logic output_limit_enable_d,
    output logic settle_detect_enable_d,
    output logic [15:0] output_limit_value_d,
    output logic [15:0] settle_target_value_d,
    output logic external_oscillator_select,
    output logic io_high_voltage,
    output logic [N_INPUTS-1:0] input_buffer_enable,
    output logic [N_INPUTS-1:0] input_pulsed_cmos,
    output logic [N_INPUTS-1:0] input_to_loop_enable,
    output logic [11:0] input_hysteresis_setting
);
    logic [7:0] ramp_q, lim_en_q, lim_lo_q, lim_hi_q, set_lo_q, set_hi_q;
    logic [7:0] osc_q, iov_q, inbuf_q, inloop_q, hys_lo_q, hys_hi_q;
    logic [7:0] rdata_q;
    logic [4:0] exp_q;
    wire [4:0] exp_w;
    wire [7:0] rd_mux;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        return a == o;
    endfunction

    rcr_ramp_scale u_scale (
        .code(ramp_q[RAMP_SCALE_LSB +: RAMP_SCALE_W]),
        .exponent(exp_w)
    );

    // Unmapped offsets read as zero; reserved bits are stored as written.
    assign rd_mux =
        hit(addr, OFS_RAMP_CTRL) ? ramp_q :
        hit(addr, OFS_LIMIT_SETTLE_EN) ? lim_en_q :
        hit(addr, OFS_LIMIT_LO) ? lim_lo_q :
        hit(addr, OFS_LIMIT_HI) ? lim_hi_q :
        hit(addr, OFS_SETTLE_LO) ? set_lo_q :
        hit(addr, OFS_SETTLE_HI) ? set_hi_q :
        hit(addr, OFS_OSC_SEL) ? osc_q :
        hit(addr, OFS_IO_VOLT) ? iov_q :
        hit(addr, OFS_IN_BUF) ? inbuf_q :
        hit(addr, OFS_IN_LOOP) ? inloop_q :
        hit(addr, OFS_HYS_LO) ? hys_lo_q :
        hit(addr, OFS_HYS_HI) ? hys_hi_q : READ_ZERO;

    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_q <= RST_BYTE;
            lim_en_q <= RST_BYTE;
            lim_lo_q <= RST_BYTE;
            lim_hi_q <= RST_BYTE;
            set_lo_q <= RST_BYTE;
            set_hi_q <= RST_BYTE;
            osc_q <= RST_BYTE;
            iov_q <= RST_IO_VOLT;
            inbuf_q <= RST_BYTE;
            inloop_q <= RST_BYTE;
            hys_lo_q <= RST_BYTE;
            hys_hi_q <= RST_BYTE;
        end else if (wr_en) begin
            if (hit(addr, OFS_RAMP_CTRL)) ramp_q <= wdata;
            if (hit(addr, OFS_LIMIT_SETTLE_EN)) lim_en_q <= wdata;
            if (hit(addr, OFS_LIMIT_LO)) lim_lo_q <= wdata;
            if (hit(addr, OFS_LIMIT_HI)) lim_hi_q <= wdata;
            if (hit(addr, OFS_SETTLE_LO)) set_lo_q <= wdata;
            if (hit(addr, OFS_SETTLE_HI)) set_hi_q <= wdata;
            if (hit(addr, OFS_OSC_SEL)) osc_q <= wdata;
            if (hit(addr, OFS_IO_VOLT)) iov_q <= wdata;
            if (hit(addr, OFS_IN_BUF)) inbuf_q <= wdata;
            if (hit(addr, OFS_IN_LOOP)) inloop_q <= wdata;
            if (hit(addr, OFS_HYS_LO)) hys_lo_q <= wdata;
            if (hit(addr, OFS_HYS_HI)) hys_hi_q <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= READ_ZERO;
            exp_q <= EXP_1X;
        end else begin
            if (rd_en) rdata_q <= rd_mux;
            exp_q <= exp_w;
        end
    end

    assign rdata = rdata_q;
    assign ramp_scale_d = ramp_q[RAMP_SCALE_LSB +: RAMP_SCALE_W];
    assign ramp_scale_exp_d = exp_q;
    assign ramped_switch_enable_d = ramp_q[RAMP_EN_BIT];
    assign output_limit_enable_d = lim_en_q[LIMIT_EN_BIT];
    assign settle_detect_enable_d = lim_en_q[SETTLE_EN_BIT];
    assign output_limit_value_d = {lim_hi_q, lim_lo_q};
    assign settle_target_value_d = {set_hi_q, set_lo_q};
    assign external_oscillator_select = osc_q[OSC_SEL_BIT];
    assign io_high_voltage = iov_q[IO_VOLT_BIT];
    assign input_buffer_enable = inbuf_q[N_INPUTS-1:0];
    assign input_pulsed_cmos = inbuf_q[PULSED_LSB +: N_INPUTS];
    assign input_to_loop_enable = inloop_q[N_INPUTS-1:0];
    assign input_hysteresis_setting = {hys_hi_q[HYS_HI_W-1:0], hys_lo_q};

    property p_ramp_en;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_RAMP_CTRL)
        |=> ramped_switch_enable_d == $past(wdata[RAMP_EN_BIT]);
    endproperty
    a_ramp_en: assert property (p_ramp_en) else $error("ramp enable");

    property p_scale;
        @(posedge clk) disable iff (srst)
        ramp_scale_d == 3'h5 ##1 ramp_scale_d == 3'h5
        |-> ramp_scale_exp_d == EXP_1024X;
    endproperty
    a_scale: assert property (p_scale) else $error("ramp scale");

    property p_iov_reset;
        @(posedge clk) srst |=> !io_high_voltage;
    endproperty
    a_iov_reset: assert property (p_iov_reset) else $error("io rst");

    property p_iov;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_IO_VOLT)
        |=> io_high_voltage == $past(wdata[IO_VOLT_BIT]);
    endproperty
    a_iov: assert property (p_iov) else $error("io voltage");

    property p_inbuf;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_IN_BUF)
        |=> input_buffer_enable == $past(wdata[N_INPUTS-1:0]);
    endproperty
    a_inbuf: assert property (p_inbuf) else $error("input enable");

    property p_pulsed;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_IN_BUF)
        |=> input_pulsed_cmos == $past(wdata[PULSED_LSB +: N_INPUTS]);
    endproperty
    a_pulsed: assert property (p_pulsed) else $error("pulsed cmos");

    property p_readback;
        @(posedge clk) disable iff (srst)
        wr_en && !rd_en && hit(addr, OFS_HYS_LO) ##1
        rd_en && !wr_en && hit(addr, OFS_HYS_LO)
        |=> rdata == $past(wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");

    property p_hold;
        @(posedge clk) disable iff (srst)
        !wr_en |=> $stable(output_limit_value_d);
    endproperty
    a_hold: assert property (p_hold) else $error("limit hold");

    // Every field follows its own write and holds when nothing addresses it, except ramp_scale_exp_d, registered one cycle after the ramp write.
    property p_limit_en;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_LIMIT_SETTLE_EN)
        |=> output_limit_enable_d == $past(wdata[LIMIT_EN_BIT])
            && settle_detect_enable_d == $past(wdata[SETTLE_EN_BIT]);
    endproperty
    a_limit_en: assert property (p_limit_en) else $error("lim en");

    property p_settle_hi;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_SETTLE_HI)
        |=> settle_target_value_d[DATA_W +: DATA_W] == $past(wdata);
    endproperty
    a_settle_hi: assert property (p_settle_hi) else $error("settle");

    property p_loop;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_IN_LOOP)
        |=> input_to_loop_enable == $past(wdata[N_INPUTS-1:0]);
    endproperty
    a_loop: assert property (p_loop) else $error("loop enable");

    property p_hys_hi;
        @(posedge clk) disable iff (srst)
        wr_en && hit(addr, OFS_HYS_HI)
        |=> input_hysteresis_setting[DATA_W +: HYS_HI_W]
            == $past(wdata[HYS_HI_W-1:0]);
    endproperty
    a_hys_hi: assert property (p_hys_hi) else $error("hysteresis");

    property p_rd_hold;
        @(posedge clk) disable iff (srst)
        !rd_en |=> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rd hold");

    property p_iov_hold;
        @(posedge clk) disable iff (srst)
        !(wr_en && hit(addr, OFS_IO_VOLT)) |=> $stable(io_high_voltage);
    endproperty
    a_iov_hold: assert property (p_iov_hold) else $error("io hold");

    c_ramp: cover property (@(posedge clk) wr_en && hit(addr, OFS_RAMP_CTRL));
    c_b2b: cover property (@(posedge clk) wr_en ##1 rd_en);
    c_iov: cover property (@(posedge clk) io_high_voltage);
    c_rd: cover property (@(posedge clk) rd_en && hit(addr, OFS_IN_BUF));
endmodule
`default_nettype wire

// *** core/rcr_pkg.sv ***
package rcr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] OFS_RAMP_CTRL = 16'h07A6;
    localparam logic [15:0] OFS_LIMIT_SETTLE_EN = 16'h07AC;
    localparam logic [15:0] OFS_LIMIT_LO = 16'h07AD;
    localparam logic [15:0] OFS_LIMIT_HI = 16'h07AE;
    localparam logic [15:0] OFS_SETTLE_LO = 16'h07B1;
    localparam logic [15:0] OFS_SETTLE_HI = 16'h07B2;
    localparam logic [15:0] OFS_OSC_SEL = 16'h090E;
    localparam logic [15:0] OFS_IO_VOLT = 16'h0943;
    localparam logic [15:0] OFS_IN_BUF = 16'h0949;
    localparam logic [15:0] OFS_IN_LOOP = 16'h094A;
    localparam logic [15:0] OFS_HYS_LO = 16'h094E;
    localparam logic [15:0] OFS_HYS_HI = 16'h094F;
    localparam int RAMP_SCALE_LSB = 0;
    localparam int RAMP_SCALE_W = 3;
    localparam int RAMP_EN_BIT = 3;
    localparam int LIMIT_EN_BIT = 0;
    localparam int SETTLE_EN_BIT = 3;
    localparam int OSC_SEL_BIT = 0;
    localparam int IO_VOLT_BIT = 0;
    localparam int N_INPUTS = 4;
    localparam int PULSED_LSB = 4;
    localparam int HYS_HI_W = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_IO_VOLT = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Ramp multiplier as a signed power of two: scale = 2^exp.
    localparam logic [4:0] EXP_1X = 5'h00;
    localparam logic [4:0] EXP_4X = 5'h02;
    localparam logic [4:0] EXP_16X = 5'h04;
    localparam logic [4:0] EXP_64X = 5'h06;
    localparam logic [4:0] EXP_256X = 5'h08;
    localparam logic [4:0] EXP_1024X = 5'h0A;
    localparam logic [4:0] EXP_QUARTER = 5'h1E;
    localparam logic [4:0] EXP_HALF = 5'h1F;
endpackage

// *** core/rcr_ramp_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcr_ramp_scale
    import rcr_pkg::*;
(
    input wire logic [2:0] code,
    output logic [4:0] exponent
);
    always_comb begin
        exponent = EXP_1X;
        unique case (code)
            3'h0: exponent = EXP_1X;
            3'h1: exponent = EXP_4X;
            3'h2: exponent = EXP_16X;
            3'h3: exponent = EXP_64X;
            3'h4: exponent = EXP_256X;
            3'h5: exponent = EXP_1024X;
            3'h6: exponent = EXP_QUARTER;
            3'h7: exponent = EXP_HALF;
        endcase
    end
endmodule
`default_nettype wire

// *** verification/ramp_and_input_config_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ramp_and_input_config_regs_test
    import rcr_pkg::*;
;
logic clk, srst, wr_en, rd_en;
logic [ADDR_W-1:0] addr;
logic [DATA_W-1:0] wdata, rdata;
logic [2:0] scale;
logic [4:0] sexp;
logic ramp_en, lim_en, set_en, osc_sel, io_hv;
logic [15:0] lim_val, set_val;
logic [3:0] buf_en, pcmos, loop_en;
logic [11:0] hys;
logic [4:0] exp_tab [8];
logic [15:0] ra [8];
logic [7:0] rv [8];
int error_cnt, checks_done;

rcr_config_regs dut (.clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .ramp_scale_d(scale),
    .ramp_scale_exp_d(sexp), .ramped_switch_enable_d(ramp_en),
    .output_limit_enable_d(lim_en), .settle_detect_enable_d(set_en),
    .output_limit_value_d(lim_val), .settle_target_value_d(set_val),
    .external_oscillator_select(osc_sel), .io_high_voltage(io_hv),
    .input_buffer_enable(buf_en), .input_pulsed_cmos(pcmos),
    .input_to_loop_enable(loop_en), .input_hysteresis_setting(hys));

initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end

task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
endtask

// Called just after a falling edge; returns one rising edge after the take, on the second falling edge.
task wr(input logic [15:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
endtask

task rdc(input string n, input logic [15:0] a, input logic [7:0] e);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk(n, rdata, e);
    @(negedge clk);
endtask

task summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask

initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
end

initial begin
    srst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    exp_tab = '{EXP_1X, EXP_4X, EXP_16X, EXP_64X, EXP_256X, EXP_1024X,
        EXP_QUARTER, EXP_HALF};
    ra = '{OFS_LIMIT_SETTLE_EN, OFS_LIMIT_LO, OFS_LIMIT_HI, OFS_SETTLE_LO,
        OFS_SETTLE_HI, OFS_IN_LOOP, OFS_HYS_LO, OFS_HYS_HI};
    rv = '{8'h09, 8'h34, 8'h12, 8'hEF, 8'hBE, 8'h0C, 8'h5A, 8'hC3};
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk("io_hv", io_hv, 16'h0000);
    rdc("io_volt", OFS_IO_VOLT, RST_IO_VOLT);
    wr(OFS_IO_VOLT, 8'h01);
    chk("io_hv", io_hv, 16'h0001);
    wr(OFS_IO_VOLT, 8'h00);
    chk("io_hv", io_hv, 16'h0000);
    for (int i = 0; i < 8; i++) begin
        wr(OFS_RAMP_CTRL, {4'h0, i[0] ^ i[1], i[2:0]});
        chk("scale", scale, i[2:0]);
        chk("scale_exp", sexp, exp_tab[i]);
        chk("ramp_en", ramp_en, i[0] ^ i[1]);
    end
    wr(OFS_IN_BUF, 8'hA5);
    chk("buf_en", buf_en, 16'h0005);
    chk("pcmos", pcmos, 16'h000A);
    wr(OFS_IN_BUF, 8'h5A);
    chk("buf_en", buf_en, 16'h000A);
    chk("pcmos", pcmos, 16'h0005);
    wr(OFS_OSC_SEL, 8'h01);
    chk("osc_sel", osc_sel, 16'h0001);
    for (int i = 0; i < 8; i++) begin
        wr(ra[i], rv[i]);
    end
    chk("lim_en", lim_en, 16'h0001);
    chk("set_en", set_en, 16'h0001);
    chk("lim_val", lim_val, 16'h1234);
    chk("set_val", set_val, 16'hBEEF);
    chk("loop_en", loop_en, 16'h000C);
    chk("hys", hys, 16'h035A);
    for (int i = 0; i < 8; i++) begin
        rdc("readback", ra[i], rv[i]);
    end
    // A read in the cycle right after a write must return the new byte.
    wr_en = 1'b1;
    addr = OFS_HYS_LO;
    wdata = 8'h96;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk("b2b", rdata, 8'h96);
    @(negedge clk);
    rdc("in_buf", OFS_IN_BUF, 8'h5A);
    wr(16'h07AF, 8'hFF);
    rdc("unmapped", 16'h07AF, READ_ZERO);
    chk("lim_val", lim_val, 16'h1234);
    wr(OFS_IO_VOLT, 8'h01);
    chk("io_hv", io_hv, 16'h0001);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk("io_hv", io_hv, 16'h0000);
    chk("buf_en", buf_en, 16'h0000);
    rdc("io_volt", OFS_IO_VOLT, RST_IO_VOLT);
    summarize();
end
endmodule
`default_nettype wire
